// file: crc_defines.svh
// constants of the clock and reset control block
`ifndef CRC_DEFINES_SVH
`define CRC_DEFINES_SVH

`define CRC_CLK_KHZ 10000
`define CRC_POR_PULSE_US 600
`define CRC_WD_PULSE_CYC 512
`define CRC_WARM_RESET_MIN_CYC 32
`define CRC_BUS_VALID_MAX_CYC 32
`define CRC_BOOT_HOLD_CYC 1000
`define CRC_OSC_START_US 3
`define CRC_XTAL_START_MIN_MS 1
`define CRC_XTAL_START_MAX_MS 10
`define CRC_POR_PULSE_CYC (`CRC_POR_PULSE_US * `CRC_CLK_KHZ / 1000)
`define CRC_OSC_START_CYC ((`CRC_OSC_START_US * `CRC_CLK_KHZ + 999) / 1000)
`define CRC_XTAL_START_CYC (`CRC_XTAL_START_MIN_MS * `CRC_CLK_KHZ)

`define CRC_OFS_BROWNOUT_CONFIG 16'h0985
`define CRC_OFS_CLOCK_OUT_CONTROL 16'h7010
`define CRC_OFS_PLL_STATUS 16'h7011
`define CRC_OFS_CLOCK_SOURCE_CONTROL 16'h7012
`define CRC_OFS_PLL_LOCK_PERIOD 16'h7013
`define CRC_OFS_OSC_ONE_TRIM 16'h7014
`define CRC_OFS_OSC_TWO_TRIM 16'h7016
`define CRC_OFS_PERIPH_CLOCK_ENABLE_TWO 16'h7019
`define CRC_OFS_LOW_SPEED_PRESCALER 16'h701b
`define CRC_OFS_PERIPH_CLOCK_ENABLE_ZERO 16'h701c
`define CRC_OFS_PERIPH_CLOCK_ENABLE_ONE 16'h701d
`define CRC_OFS_LOW_POWER_CONTROL_ZERO 16'h701e
`define CRC_OFS_PERIPH_CLOCK_ENABLE_THREE 16'h7020
`define CRC_OFS_PLL_CONTROL 16'h7021
`define CRC_OFS_SYSTEM_CONTROL_STATUS 16'h7022
`define CRC_OFS_WATCHDOG_COUNTER 16'h7023
`define CRC_OFS_WATCHDOG_SERVICE_KEY 16'h7025
`define CRC_OFS_WATCHDOG_CONTROL 16'h7029
`define CRC_OFS_DEBUG_PORT_CONTROL 16'h702a
`define CRC_OFS_SECOND_PLL_CONFIG 16'h7030
`define CRC_OFS_SECOND_PLL_MULTIPLIER 16'h7032
`define CRC_OFS_SECOND_PLL_LOCK_STATUS 16'h7034
`define CRC_OFS_SECOND_SYSCLK_COUNTER 16'h7036
`define CRC_OFS_PWM_DMA_CONFIG 16'h703a

`define CRC_NUM_REGS 24
`define CRC_IDX_PLL_STATUS 5'd2
`define CRC_IDX_CLOCK_SOURCE_CONTROL 5'd3
`define CRC_IDX_PLL_LOCK_PERIOD 5'd4
`define CRC_IDX_OSC_ONE_TRIM 5'd5
`define CRC_IDX_OSC_TWO_TRIM 5'd6
`define CRC_IDX_PLL_CONTROL 5'd13
`define CRC_IDX_WATCHDOG_COUNTER 5'd15

`define CRC_PLL_MULT_MSB 4
`define CRC_PLL_LOCKED_BIT 0
`define CRC_CLOCK_DIVIDER_SELECT_MSB 8
`define CRC_CLOCK_DIVIDER_SELECT_LSB 7
`define CRC_OSC_ONE_OFF_BIT 0
`define CRC_OSC_TWO_OFF_BIT 1
`define CRC_XTAL_ON_BIT 2
`define CRC_SRC_SEL_MSB 4
`define CRC_SRC_SEL_LSB 3

`define CRC_SRC_OSC_ONE 2'h0
`define CRC_SRC_OSC_TWO 2'h1
`define CRC_SRC_XTAL 2'h2
`define CRC_LOCK_PERIOD_RESET 16'h0100
`define CRC_REG_RESET 16'h0000

`endif

// file: crc_pkg.sv
// types of the clock and reset control block
package crc_pkg;

  typedef enum logic [1:0] {
    CRC_ST_RUN = 2'b01,
    CRC_ST_LOCK = 2'b10
  } crc_state_t;

  typedef struct packed {
    crc_state_t state;
    logic [23:0][15:0] regs;
    logic [23:0] por_cnt;
    logic [9:0] wd_cnt;
    logic [15:0] lock_cnt;
    logic [5:0] osc1_cnt;
    logic [5:0] osc2_cnt;
    logic [23:0] xtal_cnt;
    logic osc1_ready;
    logic osc2_ready;
    logic xtal_ready;
    logic osc1_en;
    logic osc2_en;
    logic xtal_en;
    logic [1:0] src_sel;
    logic [4:0] mult;
    logic [1:0] div_shift;
    logic [15:0] rdata;
    logic pin_oe;
    logic wd_reset;
    logic bus_active;
    logic pin_sync1;
    logic pin_sync2;
  } crc_state_s_t;

endpackage : crc_pkg

// file: crc_clock_reset.sv
// clock and reset control: reset pulses, pll lock-up, oscillator select, registers
// How it works
// - device-driven reset pin pulse lasts 600 us
// - watchdog reset pulse lasts 512 oscillator cycles
// - bus activity valid within 32 cycles
// - internal oscillator usable 3 us after start
// - crystal counted valid after start-up time
// - pll write starts lock-up, then new rate
// - both internal oscillators enabled at power-up
// - internal oscillator one selected at power-up
// - software may power down unused oscillators
// - oscillator frequency follows its trim register
// - all map registers write-protected
// - core clock equals forwarded system clock rate
// - pll control and status registers reset by pin or watchdog only
`timescale 1ns/1ps
`default_nettype none
`include "crc_defines.svh"

module crc_clock_reset
  import crc_pkg::*;
#(
  parameter int unsigned POR_PULSE_CYC = `CRC_POR_PULSE_CYC,
  parameter int unsigned XTAL_START_CYC = `CRC_XTAL_START_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic external_reset_n_in,
  output logic external_reset_n_out,
  output logic external_reset_n_oe,
  input wire logic brownout_event,
  input wire logic watchdog_expire,
  input wire logic debug_reset,
  input wire logic missing_clock_reset,
  input wire logic protected_write_enable,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic watchdog_reset_out,
  output logic bus_active,
  output logic internal_osc_one_enable,
  output logic internal_osc_two_enable,
  output logic crystal_enable,
  output logic [15:0] osc_one_trim_out,
  output logic [15:0] osc_two_trim_out,
  output logic [1:0] clock_source,
  output logic [4:0] sysclk_multiplier,
  output logic [1:0] sysclk_div_shift,
  output logic pll_locked_flag
);

  crc_state_s_t cur_ff;
  crc_state_s_t nxt_cur;

  // maps a bus address to a register slot
  function automatic logic [5:0] crc_decode(input logic [15:0] addr);
    logic [5:0] res;
    res = 6'h00;
    unique case (addr)
      `CRC_OFS_BROWNOUT_CONFIG: res = {1'b1, 5'd0};
      `CRC_OFS_CLOCK_OUT_CONTROL: res = {1'b1, 5'd1};
      `CRC_OFS_PLL_STATUS: res = {1'b1, 5'd2};
      `CRC_OFS_CLOCK_SOURCE_CONTROL: res = {1'b1, 5'd3};
      `CRC_OFS_PLL_LOCK_PERIOD: res = {1'b1, 5'd4};
      `CRC_OFS_OSC_ONE_TRIM: res = {1'b1, 5'd5};
      `CRC_OFS_OSC_TWO_TRIM: res = {1'b1, 5'd6};
      `CRC_OFS_PERIPH_CLOCK_ENABLE_TWO: res = {1'b1, 5'd7};
      `CRC_OFS_LOW_SPEED_PRESCALER: res = {1'b1, 5'd8};
      `CRC_OFS_PERIPH_CLOCK_ENABLE_ZERO: res = {1'b1, 5'd9};
      `CRC_OFS_PERIPH_CLOCK_ENABLE_ONE: res = {1'b1, 5'd10};
      `CRC_OFS_LOW_POWER_CONTROL_ZERO: res = {1'b1, 5'd11};
      `CRC_OFS_PERIPH_CLOCK_ENABLE_THREE: res = {1'b1, 5'd12};
      `CRC_OFS_PLL_CONTROL: res = {1'b1, 5'd13};
      `CRC_OFS_SYSTEM_CONTROL_STATUS: res = {1'b1, 5'd14};
      `CRC_OFS_WATCHDOG_COUNTER: res = {1'b1, 5'd15};
      `CRC_OFS_WATCHDOG_SERVICE_KEY: res = {1'b1, 5'd16};
      `CRC_OFS_WATCHDOG_CONTROL: res = {1'b1, 5'd17};
      `CRC_OFS_DEBUG_PORT_CONTROL: res = {1'b1, 5'd18};
      `CRC_OFS_SECOND_PLL_CONFIG: res = {1'b1, 5'd19};
      `CRC_OFS_SECOND_PLL_MULTIPLIER: res = {1'b1, 5'd20};
      `CRC_OFS_SECOND_PLL_LOCK_STATUS: res = {1'b1, 5'd21};
      `CRC_OFS_SECOND_SYSCLK_COUNTER: res = {1'b1, 5'd22};
      `CRC_OFS_PWM_DMA_CONFIG: res = {1'b1, 5'd23};
      default: res = 6'h00;
    endcase
    return res;
  endfunction : crc_decode

  // divider select code to shift: 0 and 1 divide by four
  function automatic logic [1:0] crc_div_shift(input logic [1:0] clock_divider_select);
    logic [1:0] res;
    res = 2'h2;
    if (clock_divider_select == 2'h2) begin
      res = 2'h1;
    end else if (clock_divider_select == 2'h3) begin
      res = 2'h0;
    end
    return res;
  endfunction : crc_div_shift

  // oscillator start counter, ready once it reaches the start-up time
  function automatic logic [5:0] crc_osc_step(input logic on, input logic [5:0] cnt);
    logic [5:0] res;
    res = 6'h00;
    if (on && cnt < 6'(`CRC_OSC_START_CYC)) begin
      res = cnt + 6'h01;
    end else if (on) begin
      res = cnt;
    end
    return res;
  endfunction : crc_osc_step

  logic [5:0] dec;
  logic wr_hit;
  logic pin_low;
  logic full_reset;
  logic soft_reset;
  logic [15:0] src_ctl;
  logic [1:0] want_src;
  logic osc1_on;
  logic osc2_on;
  logic xtal_on;

  always_comb begin
    nxt_cur = cur_ff;
    dec = crc_decode(reg_addr);
    wr_hit = reg_wr && dec[5] && protected_write_enable;
    // pin level seen by logic only after the second flop
    nxt_cur.pin_sync1 = external_reset_n_in;
    nxt_cur.pin_sync2 = cur_ff.pin_sync1;
    pin_low = !cur_ff.pin_sync2;
    full_reset = pin_low || cur_ff.wd_reset;
    soft_reset = full_reset || debug_reset || missing_clock_reset;
    src_ctl = cur_ff.regs[`CRC_IDX_CLOCK_SOURCE_CONTROL];
    want_src = src_ctl[`CRC_SRC_SEL_MSB:`CRC_SRC_SEL_LSB];

    // device-driven reset pulse on the open-drain pin
    if (brownout_event) begin
      nxt_cur.por_cnt = 24'(POR_PULSE_CYC);
    end else if (cur_ff.por_cnt != 24'h000000) begin
      nxt_cur.por_cnt = cur_ff.por_cnt - 24'h000001;
    end
    nxt_cur.pin_oe = (nxt_cur.por_cnt != 24'h000000);

    // watchdog reset pulse
    if (watchdog_expire && !cur_ff.wd_reset) begin
      nxt_cur.wd_cnt = 10'(`CRC_WD_PULSE_CYC);
    end else if (cur_ff.wd_cnt != 10'h000) begin
      nxt_cur.wd_cnt = cur_ff.wd_cnt - 10'h001;
    end
    nxt_cur.wd_reset = (nxt_cur.wd_cnt != 10'h000);

    // activity follows the synchronised pin within three cycles
    nxt_cur.bus_active = !pin_low && !cur_ff.pin_oe && !cur_ff.wd_reset;

    // register writes
    if (wr_hit && dec[4:0] != `CRC_IDX_WATCHDOG_COUNTER) begin
      nxt_cur.regs[dec[4:0]] = reg_wdata;
    end

    // pll lock-up sequencing
    unique case (cur_ff.state)
      CRC_ST_RUN: begin
        if (wr_hit && dec[4:0] == `CRC_IDX_PLL_CONTROL) begin
          nxt_cur.state = CRC_ST_LOCK;
          nxt_cur.lock_cnt = cur_ff.regs[`CRC_IDX_PLL_LOCK_PERIOD];
          nxt_cur.mult = 5'h00;
        end
      end
      CRC_ST_LOCK: begin
        // a rewrite during lock-up restarts the lock period
        if (wr_hit && dec[4:0] == `CRC_IDX_PLL_CONTROL) begin
          nxt_cur.lock_cnt = cur_ff.regs[`CRC_IDX_PLL_LOCK_PERIOD];
        end else if (cur_ff.lock_cnt != 16'h0000) begin
          nxt_cur.lock_cnt = cur_ff.lock_cnt - 16'h0001;
        end else begin
          nxt_cur.state = CRC_ST_RUN;
          nxt_cur.mult = cur_ff.regs[`CRC_IDX_PLL_CONTROL][`CRC_PLL_MULT_MSB:0];
        end
      end
    endcase
    nxt_cur.regs[`CRC_IDX_PLL_STATUS][`CRC_PLL_LOCKED_BIT] = (nxt_cur.state == CRC_ST_RUN);
    // divider applies in lock-up too; software keeps it zero then
    nxt_cur.div_shift = crc_div_shift(
      nxt_cur.regs[`CRC_IDX_PLL_STATUS][`CRC_CLOCK_DIVIDER_SELECT_MSB:`CRC_CLOCK_DIVIDER_SELECT_LSB]);

    // oscillator power and start-up: the selected source is never powered off
    osc1_on = !src_ctl[`CRC_OSC_ONE_OFF_BIT] || cur_ff.src_sel == `CRC_SRC_OSC_ONE;
    osc2_on = !src_ctl[`CRC_OSC_TWO_OFF_BIT] || cur_ff.src_sel == `CRC_SRC_OSC_TWO;
    xtal_on = src_ctl[`CRC_XTAL_ON_BIT] || cur_ff.src_sel == `CRC_SRC_XTAL;
    nxt_cur.osc1_cnt = crc_osc_step(osc1_on, cur_ff.osc1_cnt);
    nxt_cur.osc2_cnt = crc_osc_step(osc2_on, cur_ff.osc2_cnt);
    nxt_cur.osc1_ready = (nxt_cur.osc1_cnt == 6'(`CRC_OSC_START_CYC));
    nxt_cur.osc2_ready = (nxt_cur.osc2_cnt == 6'(`CRC_OSC_START_CYC));
    if (!xtal_on) begin
      nxt_cur.xtal_cnt = 24'h000000;
    end else if (cur_ff.xtal_cnt < 24'(XTAL_START_CYC)) begin
      nxt_cur.xtal_cnt = cur_ff.xtal_cnt + 24'h000001;
    end
    nxt_cur.xtal_ready = (nxt_cur.xtal_cnt == 24'(XTAL_START_CYC));
    // enables registered so the pins come straight from flops
    nxt_cur.osc1_en = (nxt_cur.osc1_cnt != 6'h00);
    nxt_cur.osc2_en = (nxt_cur.osc2_cnt != 6'h00);
    nxt_cur.xtal_en = (nxt_cur.xtal_cnt != 24'h000000);

    // switch only to a source that has finished starting up
    unique case (want_src)
      `CRC_SRC_OSC_ONE: begin
        if (cur_ff.osc1_ready) begin
          nxt_cur.src_sel = `CRC_SRC_OSC_ONE;
        end
      end
      `CRC_SRC_OSC_TWO: begin
        if (cur_ff.osc2_ready) begin
          nxt_cur.src_sel = `CRC_SRC_OSC_TWO;
        end
      end
      `CRC_SRC_XTAL: begin
        if (cur_ff.xtal_ready) begin
          nxt_cur.src_sel = `CRC_SRC_XTAL;
        end
      end
      default: begin
        nxt_cur.src_sel = cur_ff.src_sel;
      end
    endcase

    // read data, one cycle after the strobe
    nxt_cur.rdata = 16'h0000;
    if (reg_rd && dec[5] && dec[4:0] != `CRC_IDX_WATCHDOG_COUNTER) begin
      nxt_cur.rdata = cur_ff.regs[dec[4:0]];
    end

    // debug and missing-clock resets spare the pll control and status registers; pin and watchdog reset them
    if (soft_reset) begin
      for (int i = 0; i < `CRC_NUM_REGS; i++) begin
        if (5'(i) != `CRC_IDX_PLL_CONTROL && 5'(i) != `CRC_IDX_PLL_STATUS) begin
          nxt_cur.regs[i] = `CRC_REG_RESET;
        end
      end
      nxt_cur.regs[`CRC_IDX_PLL_LOCK_PERIOD] = `CRC_LOCK_PERIOD_RESET;
    end
    if (full_reset) begin
      nxt_cur.regs[`CRC_IDX_PLL_CONTROL] = `CRC_REG_RESET;
      nxt_cur.regs[`CRC_IDX_PLL_STATUS] = 16'h0001;
      nxt_cur.state = CRC_ST_RUN;
      nxt_cur.lock_cnt = 16'h0000;
      nxt_cur.mult = 5'h00;
      nxt_cur.div_shift = crc_div_shift(2'h0);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cur_ff <= '0;
      cur_ff.state <= CRC_ST_RUN;
      cur_ff.regs[`CRC_IDX_PLL_LOCK_PERIOD] <= `CRC_LOCK_PERIOD_RESET;
      cur_ff.regs[`CRC_IDX_PLL_STATUS] <= 16'h0001;
      cur_ff.por_cnt <= 24'(POR_PULSE_CYC);
      cur_ff.pin_oe <= 1'b1;
      cur_ff.src_sel <= `CRC_SRC_OSC_ONE;
      cur_ff.osc1_en <= 1'b1;
      cur_ff.osc2_en <= 1'b1;
      // idle level of the pin, so release does not look like a pin reset
      cur_ff.pin_sync1 <= 1'b1;
      cur_ff.pin_sync2 <= 1'b1;
      cur_ff.div_shift <= 2'h2;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign external_reset_n_out = 1'b0;
  assign external_reset_n_oe = cur_ff.pin_oe;
  assign reg_rdata = cur_ff.rdata;
  assign watchdog_reset_out = cur_ff.wd_reset;
  assign bus_active = cur_ff.bus_active;
  // offs bits reset to zero, so both oscillators run from power-up
  assign internal_osc_one_enable = cur_ff.osc1_en;
  assign internal_osc_two_enable = cur_ff.osc2_en;
  assign crystal_enable = cur_ff.xtal_en;
  assign osc_one_trim_out = cur_ff.regs[`CRC_IDX_OSC_ONE_TRIM];
  assign osc_two_trim_out = cur_ff.regs[`CRC_IDX_OSC_TWO_TRIM];
  assign clock_source = cur_ff.src_sel;
  // one multiplier/shift pair sets both core and forwarded clock
  assign sysclk_multiplier = cur_ff.mult;
  assign sysclk_div_shift = cur_ff.div_shift;
  assign pll_locked_flag = cur_ff.regs[`CRC_IDX_PLL_STATUS][`CRC_PLL_LOCKED_BIT];

endmodule : crc_clock_reset
`default_nettype wire

// file: crc_clock_reset_assertions.sv
// port-level checks of the clock and reset control block
`timescale 1ns/1ps
`default_nettype none
module crc_clock_reset_assertions #(
  parameter int unsigned POR_PULSE_CYC = 6000
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic external_reset_n_in,
  input wire logic external_reset_n_oe,
  input wire logic watchdog_expire,
  input wire logic protected_write_enable,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic watchdog_reset_out,
  input wire logic bus_active,
  input wire logic internal_osc_one_enable,
  input wire logic internal_osc_two_enable,
  input wire logic [15:0] osc_one_trim_out,
  input wire logic [1:0] clock_source,
  input wire logic [4:0] sysclk_multiplier,
  input wire logic pll_locked_flag
);
  logic [9:0] wd_n_ff;
  logic [15:0] por_n_ff;
  logic [4:0] mult_ff;
  wire en_wr = reg_wr && protected_write_enable;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // pulse lengths counted here, far too long to unroll
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wd_n_ff <= 10'h0;
      por_n_ff <= 16'h0;
      mult_ff <= 5'h0;
    end else begin
      wd_n_ff <= watchdog_reset_out ? wd_n_ff + 10'h1 : 10'h0;
      por_n_ff <= external_reset_n_oe ? por_n_ff + 16'h1 : 16'h0;
      if (en_wr && reg_addr == 16'h7021) begin
        mult_ff <= reg_wdata[4:0];
      end
    end
  end
  sequence s_pll_wr;
    en_wr && reg_addr == 16'h7021;
  endsequence
  sequence s_bypass;
    !pll_locked_flag && sysclk_multiplier == 5'h0;
  endsequence
  a_wd_start: assert property (watchdog_expire && !watchdog_reset_out |=> watchdog_reset_out)
    else $error("watchdog pulse did not start");
  a_wd_length: assert property (!watchdog_reset_out && wd_n_ff != 10'h0 |-> wd_n_ff == 10'h200)
    else $error("watchdog pulse length wrong");
  a_pin_pulse_len: assert property (!external_reset_n_oe && por_n_ff != 16'h0 |-> por_n_ff == POR_PULSE_CYC)
    else $error("pin pulse length wrong");
  a_bus_up: assert property ($rose(external_reset_n_in) && !external_reset_n_oe && !watchdog_reset_out |-> ##[1:32] bus_active)
    else $error("bus not active in time");
  a_bus_down: assert property ((!external_reset_n_in)[*3] |=> !bus_active)
    else $error("bus active while pin low");
  a_pll_start: assert property (s_pll_wr |=> s_bypass)
    else $error("lock-up not entered");
  a_pll_lock: assert property ($rose(pll_locked_flag) |-> sysclk_multiplier == mult_ff)
    else $error("wrong multiplier after lock");
  a_osc_power: assert property ($rose(rst_b) |-> ##[1:2] (internal_osc_one_enable && internal_osc_two_enable && clock_source == 2'h0))
    else $error("oscillator state after reset wrong");
  a_trim_write: assert property (en_wr && reg_addr == 16'h7014 |=> osc_one_trim_out == $past(reg_wdata))
    else $error("trim not applied");
  a_write_block: assert property (reg_wr && !protected_write_enable |=> $stable(osc_one_trim_out))
    else $error("unprotected write took effect");
endmodule : crc_clock_reset_assertions
`default_nettype wire

// file: crc_board_model.sv
// board side of the reset pin: pull-up and warm reset driver
`timescale 1ns/1ps
`default_nettype none
module crc_board_model #(
  parameter int unsigned WARM_CYC = 32
) (
  input wire logic clock,
  input wire logic warm_req,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  int hold = 0;
  always @(posedge clock) begin
    // boot straps are not wired here; the board keeps them still long after reset
    if (warm_req) hold <= WARM_CYC;
    else if (hold > 0) hold <= hold - 1;
  end
  // open drain: pull-up wins unless someone pulls low
  assign pin_level = (pin_oe ? pin_out : 1'b1) & (hold == 0);
endmodule : crc_board_model
`default_nettype wire

// file: crc_clock_reset_tb.sv
// self-checking bench of the clock and reset control block
`timescale 1ns/1ps
`default_nettype none
bind crc_clock_reset crc_clock_reset_assertions #(.POR_PULSE_CYC(POR_PULSE_CYC)) u_chk (
  .clock, .rst_b, .external_reset_n_in, .external_reset_n_oe, .watchdog_expire,
  .protected_write_enable, .reg_addr, .reg_wdata, .reg_wr, .watchdog_reset_out, .bus_active,
  .internal_osc_one_enable, .internal_osc_two_enable, .osc_one_trim_out, .clock_source,
  .sysclk_multiplier, .pll_locked_flag);
module crc_clock_reset_tb;
  localparam int unsigned POR = 20;
  logic clock = 1'b0, rst_b = 1'b0, brownout_event = 1'b0, watchdog_expire = 1'b0;
  logic debug_reset = 1'b0, protected_write_enable = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic warm_req = 1'b0, rd_seen = 1'b0, pin, pin_out, pin_oe, wd_out, bus_act, osc1, osc2;
  logic pll_locked_flag;
  logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata, trim1, trim2;
  logic xtal;
  logic [1:0] src, div_shift;
  logic [4:0] mult;
  logic [31:0] rng = 32'h3563e212;
  logic [15:0] exp_q[$];
  logic [15:0] ofs[17] = '{16'h0985, 16'h7010, 16'h7014, 16'h7016, 16'h7019, 16'h701b,
    16'h701c, 16'h701d, 16'h701e, 16'h7020, 16'h7022, 16'h7025, 16'h7029, 16'h702a,
    16'h7030, 16'h7032, 16'h703a};
  int err_count = 0, cmp_count = 0, cyc = 0;
  crc_clock_reset #(.POR_PULSE_CYC(POR), .XTAL_START_CYC(20)) i_dut (
    .clock, .rst_b, .external_reset_n_in(pin), .external_reset_n_out(pin_out),
    .external_reset_n_oe(pin_oe), .brownout_event, .watchdog_expire, .debug_reset,
    .missing_clock_reset(1'b0), .protected_write_enable, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .watchdog_reset_out(wd_out), .bus_active(bus_act),
    .internal_osc_one_enable(osc1), .internal_osc_two_enable(osc2), .crystal_enable(xtal),
    .osc_one_trim_out(trim1), .osc_two_trim_out(trim2), .clock_source(src),
    .sysclk_multiplier(mult), .sysclk_div_shift(div_shift), .pll_locked_flag);
  crc_board_model i_board (.clock, .warm_req, .pin_out, .pin_oe, .pin_level(pin));
  always #50 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic results;
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic en);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    protected_write_enable <= en;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask : rd
  // 0 debug reset, 1 watchdog, 2 warm reset, 3 brownout
  task automatic pulse(input int sel);
    @(posedge clock);
    if (sel == 0) debug_reset <= 1'b1;
    else if (sel == 1) watchdog_expire <= 1'b1;
    else if (sel == 2) warm_req <= 1'b1;
    else brownout_event <= 1'b1;
    @(posedge clock);
    debug_reset <= 1'b0;
    watchdog_expire <= 1'b0;
    warm_req <= 1'b0;
    brownout_event <= 1'b0;
  endtask : pulse
  // read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_seen) cmp(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    settle(POR + 10);
    cmp(16'(src), 16'h0);
    cmp(16'({osc1, osc2}), 16'h3);
    cmp(16'(div_shift), 16'h2);
    rd(16'h7013, 16'h0100);
    rd(16'h7011, 16'h0001);
    foreach (ofs[i]) begin
      rng = xs(rng);
      wr(ofs[i], rng[15:0], 1'b1);
      rd(ofs[i], rng[15:0]);
    end
    wr(16'h7014, 16'h1234, 1'b1);
    wr(16'h7014, 16'h00aa, 1'b0);
    rd(16'h7014, 16'h1234);
    wr(16'h7023, 16'hffff, 1'b1);
    rd(16'h7023, 16'h0);
    wr(16'h7015, 16'hffff, 1'b1);
    rd(16'h7015, 16'h0);
    for (int i = 3; i >= 0; i--) begin
      wr(16'h7011, 16'(i) << 7, 1'b1);
      settle(1);
      cmp(16'(div_shift), (i < 2) ? 16'h2 : 16'(3 - i));
    end
    wr(16'h7013, 16'h0004, 1'b1);
    wr(16'h7021, 16'h0005, 1'b1);
    #1;
    cmp(16'({pll_locked_flag, mult}), 16'h0);
    for (int i = 0; i < 20 && pll_locked_flag !== 1'b1; i++) settle(1);
    cmp(16'({pll_locked_flag, mult}), 16'h25);
    pulse(0);
    rd(16'h7021, 16'h0005);
    rd(16'h7014, 16'h0);
    wr(16'h7012, 16'h0002, 1'b1);
    settle(3);
    cmp(16'({osc2, src}), 16'h0);
    wr(16'h7016, 16'h4321, 1'b1);
    settle(1);
    cmp(trim2, 16'h4321);
    wr(16'h7012, 16'h0014, 1'b1);
    settle(25);
    cmp(16'({xtal, src}), 16'h6);
    pulse(1);
    settle(1);
    cmp(16'(wd_out), 16'h1);
    settle(540);
    cmp(16'({wd_out, bus_act}), 16'h1);
    rd(16'h7021, 16'h0);
    rd(16'h7013, 16'h0100);
    wr(16'h7014, 16'h5a5a, 1'b1);
    pulse(2);
    settle(80);
    cmp(16'(bus_act), 16'h1);
    rd(16'h7014, 16'h0);
    pulse(3);
    settle(2);
    cmp(16'(pin_oe), 16'h1);
    settle(POR + 40);
    cmp(16'({pin_oe, bus_act}), 16'h1);
    settle(3);
    results();
  end
endmodule : crc_clock_reset_tb
`default_nettype wire
